// [design/pulse_counter_period_timer.v]
// Eight-channel pulse counter bank with register port and interrupt
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_counter_consts.vh"
// Notes on behaviour
// - Eight counters, index 0 to 7, are chosen by a selector before configuring or reading.
// - A per-channel register access while the selector holds the invalid code is refused and raises an error.
// - Each counter keeps a programmable stall timeout that defaults to fifty milliseconds.
// - Each counter keeps an averaging depth of 1 to 128 samples that defaults to one.
// - The reported period is the mean of the most recent programmed number of intervals.
// - A counter is flagged stopped when no counted pulse arrives for the whole stall timeout.
// - The count keeps accumulating across reads and clears only on a reset command.
// - Past its maximum the count wraps to zero and keeps counting.
// - The direction flag is high after an increment and low after a decrement.
// - Every read returns the selected index or the invalid code; only refused channel accesses also raise an error.
// - Each counter counts rising or falling edges, from separate up and down sources.
// - A reset command zeroes the count and a stop command halts it without clearing.
module pulse_counter_period_timer #(
   parameter NUM_CHANNELS = 8,
   parameter [31:0] STALL_DEFAULT = `STALL_TIMEOUT_CYC
)(
   input wire i_clock,
   input wire i_resetn,
   input wire [7:0] i_up_pins,
   input wire [7:0] i_down_pins,
   input wire [7:0] i_address,
   input wire [31:0] i_write_data,
   input wire i_write,
   input wire i_read,
   output reg [31:0] o_read_data,
   output reg [3:0] o_read_select,
   output reg o_read_error,
   output wire o_interrupt
);
   // ==================================================
   // Reset release
   reg [1:0] rst_sync_q;
   wire reset;
   always @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign reset = ~rst_sync_q[1];

   // ==================================================
   // Per-channel configuration
   reg [3:0] counter_select_q;
   reg [7:0] run_q;
   reg [7:0] falling_q;
   reg [7:0] down_en_q;
   reg [7:0] clear_q;
   reg [31:0] stall_timeout_q [0:7];
   reg [7:0] avg_sample_count_q [0:7];
   wire sel_valid;
   wire [2:0] sel;
   assign sel = counter_select_q[2:0];
   assign sel_valid = ~counter_select_q[3];
   wire wr_sel;
   wire wr_ctrl;
   wire wr_tmo;
   wire wr_avg;
   assign wr_sel = i_write & (i_address == `ADDR_SELECT);
   assign wr_ctrl = i_write & (i_address == `ADDR_CTRL);
   assign wr_tmo = i_write & (i_address == `ADDR_TIMEOUT);
   assign wr_avg = i_write & (i_address == `ADDR_AVG);
   // Per-channel operation needs a valid selector; else it is refused
   wire chan_op;
   assign chan_op = (wr_ctrl | wr_tmo | wr_avg | (i_read & ((i_address == `ADDR_CTRL) |
      (i_address == `ADDR_TIMEOUT) | (i_address == `ADDR_AVG) | (i_address == `ADDR_COUNT) |
      (i_address == `ADDR_PERIOD) | (i_address == `ADDR_STATUS))));
   wire op_error;
   assign op_error = chan_op & ~sel_valid;
   integer k;
   // Configuration writes land only on the selected channel
   always @(posedge i_clock or posedge reset)
   begin
      if (reset)
      begin
         counter_select_q <= `SEL_INVALID;
         run_q <= 8'h0;
         falling_q <= 8'h0;
         down_en_q <= 8'h0;
         clear_q <= 8'h0;
         for (k = 0; k < 8; k = k + 1)
         begin
            stall_timeout_q[k] <= STALL_DEFAULT;
            avg_sample_count_q[k] <= `AVG_DEFAULT;
         end
      end
      else
      begin
         clear_q <= 8'h0;
         if (wr_sel)
            counter_select_q <= (i_write_data[31:3] == 29'h0) ? {1'b0, i_write_data[2:0]} : `SEL_INVALID;
         if (wr_ctrl & sel_valid)
         begin
            run_q[sel] <= i_write_data[`CTRL_RUN]; // Stop keeps the count
            falling_q[sel] <= i_write_data[`CTRL_FALL];
            down_en_q[sel] <= i_write_data[`CTRL_DOWN_EN];
            clear_q[sel] <= i_write_data[`CTRL_RESET];
         end
         if (wr_tmo & sel_valid)
            stall_timeout_q[sel] <= i_write_data;
         if (wr_avg & sel_valid)
            avg_sample_count_q[sel] <= (i_write_data[31:8] != 24'h0) ? `AVG_MAX :
               (i_write_data[7:0] == 8'h0) ? `AVG_DEFAULT :
               (i_write_data[7:0] > `AVG_MAX) ? `AVG_MAX : i_write_data[7:0];
      end
   end

   // ==================================================
   // Channel array
   wire [31:0] count_w [0:7];
   wire [31:0] period_w [0:7];
   wire [7:0] dir_w;
   wire [7:0] stopped_w;
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g = g + 1)
      begin : chan
         pulse_channel u_channel (
            .i_clock(i_clock),
            .i_reset(reset),
            .i_up_pin(i_up_pins[g]),
            .i_down_pin(i_down_pins[g]),
            .i_run(run_q[g]),
            .i_falling(falling_q[g]),
            .i_down_en(down_en_q[g]),
            .i_clear(clear_q[g]),
            .i_stall_timeout(stall_timeout_q[g]),
            .i_avg_depth(avg_sample_count_q[g]),
            .o_count(count_w[g]),
            .o_direction(dir_w[g]),
            .o_stopped(stopped_w[g]),
            .o_period(period_w[g])
         );
      end
   endgenerate

   // ==================================================
   // Interrupt status and mask
   reg [1:0] irq_stat_q;
   reg [1:0] irq_mask_q;
   reg [7:0] stopped_prev_q;
   wire stop_event;
   assign stop_event = |(stopped_w & ~stopped_prev_q);
   // Set beats write-one-to-clear in the same cycle
   always @(posedge i_clock or posedge reset)
   begin
      if (reset)
      begin
         irq_stat_q <= 2'h0;
         irq_mask_q <= 2'h0;
         stopped_prev_q <= 8'h0;
      end
      else
      begin
         stopped_prev_q <= stopped_w;
         if (i_write & (i_address == `ADDR_IRQ_MASK))
            irq_mask_q <= i_write_data[1:0];
         irq_stat_q[`IRQ_ERROR] <= op_error |
            (irq_stat_q[`IRQ_ERROR] & ~(i_write & (i_address == `ADDR_IRQ_STAT) & i_write_data[`IRQ_ERROR]));
         irq_stat_q[`IRQ_STOP] <= stop_event |
            (irq_stat_q[`IRQ_STOP] & ~(i_write & (i_address == `ADDR_IRQ_STAT) & i_write_data[`IRQ_STOP]));
      end
   end
   assign o_interrupt = |(irq_stat_q & irq_mask_q);

   // ==================================================
   // Read port
   reg [31:0] rd_d;
   // Unmapped addresses read as zero; refused reads show the error word 32'h4
   always @*
   begin
      rd_d = 32'h0;
      case (i_address)
         `ADDR_SELECT: rd_d = {28'h0, counter_select_q};
         `ADDR_CTRL: rd_d = {29'h0, down_en_q[sel], falling_q[sel], run_q[sel]};
         `ADDR_TIMEOUT: rd_d = stall_timeout_q[sel];
         `ADDR_AVG: rd_d = {24'h0, avg_sample_count_q[sel]};
         `ADDR_COUNT: rd_d = count_w[sel]; // Read leaves the count alone
         `ADDR_PERIOD: rd_d = period_w[sel];
         `ADDR_STATUS: rd_d = {29'h0, 1'b0, stopped_w[sel], dir_w[sel]};
         `ADDR_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
         `ADDR_IRQ_MASK: rd_d = {30'h0, irq_mask_q};
         default: rd_d = 32'h0;
      endcase
      if (op_error)
         rd_d = {29'h0, 1'b1, 2'h0}; // Error bit in status position
   end
   // Data, index and error stand for one cycle after the read strobe
   always @(posedge i_clock or posedge reset)
   begin
      if (reset)
      begin
         o_read_data <= 32'h0;
         o_read_select <= `SEL_INVALID;
         o_read_error <= 1'b0;
      end
      else if (i_read)
      begin
         o_read_data <= rd_d;
         o_read_select <= sel_valid ? counter_select_q : `SEL_INVALID;
         o_read_error <= op_error;
      end
      else
      begin
         o_read_data <= 32'h0;
         o_read_select <= `SEL_INVALID;
         o_read_error <= 1'b0;
      end
   end
endmodule // pulse_counter_period_timer
`default_nettype wire

// [design/pulse_counter_consts.vh]
// Constants for the pulse counter bank: offsets, fields, resets and timing
`ifndef PULSE_COUNTER_CONSTS_VH
`define PULSE_COUNTER_CONSTS_VH
// Register word addresses (8-bit address port)
`define ADDR_SELECT 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_TIMEOUT 8'h08
`define ADDR_AVG 8'h0c
`define ADDR_COUNT 8'h10
`define ADDR_PERIOD 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_IRQ_STAT 8'h1c
`define ADDR_IRQ_MASK 8'h20
// Selector layout: bits 2:0 index, bit 3 marks the invalid code
`define SEL_INVALID 4'h8
// Control register fields of the selected counter
`define CTRL_RUN 0
`define CTRL_FALL 1
`define CTRL_DOWN_EN 2
`define CTRL_RESET 3
// Status word fields
`define ST_DIR 0
`define ST_STOPPED 1
`define ST_ERROR 2
// Interrupt status fields
`define IRQ_ERROR 0
`define IRQ_STOP 1
// Reset values and timing
`define STALL_TIMEOUT_S 0.05
`define CLOCK_HZ 100000000
`define STALL_TIMEOUT_CYC 32'h004c4b40
`define AVG_DEFAULT 8'h01
`define AVG_MAX 8'h80
`endif

// [design/pulse_channel.v]
// One pulse counter channel with period averaging and stall detection
`timescale 1ns/100ps
`default_nettype none
`include "pulse_counter_consts.vh"
module pulse_channel #(
   parameter SYNC_STAGES = 3
)(
   input wire i_clock,
   input wire i_reset,
   input wire i_up_pin,
   input wire i_down_pin,
   input wire i_run,
   input wire i_falling,
   input wire i_down_en,
   input wire i_clear,
   input wire [31:0] i_stall_timeout,
   input wire [7:0] i_avg_depth,
   output reg [31:0] o_count,
   output reg o_direction,
   output reg o_stopped,
   output reg [31:0] o_period
);
   // ==================================================
   // Input synchronisers
   reg [2:0] up_sync_q;
   reg [2:0] dn_sync_q;
   reg up_lvl_q;
   reg dn_lvl_q;
   wire up_step;
   wire dn_step;
   wire up_agree;
   wire dn_agree;
   assign up_agree = (up_sync_q[1] == up_sync_q[2]);
   assign dn_agree = (dn_sync_q[1] == dn_sync_q[2]);
   // Stage 0 feeds only stage 1; level moves when stages 1 and 2 agree
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         up_sync_q <= 3'h0;
         dn_sync_q <= 3'h0;
         up_lvl_q <= 1'b0;
         dn_lvl_q <= 1'b0;
      end
      else
      begin
         up_sync_q <= {up_sync_q[1:0], i_up_pin};
         dn_sync_q <= {dn_sync_q[1:0], i_down_pin};
         if (up_agree)
            up_lvl_q <= up_sync_q[2];
         if (dn_agree)
            dn_lvl_q <= dn_sync_q[2];
      end
   end
   // Edge selection: rising or falling per configuration
   assign up_step = i_run & up_agree & (up_lvl_q != up_sync_q[2]) & (up_sync_q[2] ^ i_falling);
   assign dn_step = i_run & i_down_en & dn_agree & (dn_lvl_q != dn_sync_q[2])
      & (dn_sync_q[2] ^ i_falling);

   // ==================================================
   // Count and direction
   wire any_step;
   assign any_step = up_step ^ dn_step;
   // Simultaneous up and down cancel out, so neither moves the count
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_count <= 32'h0;
         o_direction <= 1'b1;
      end
      else if (i_clear)
         o_count <= 32'h0;
      else if (up_step & ~dn_step)
      begin
         o_count <= o_count + 32'h1; // Wraps to zero past the top
         o_direction <= 1'b1;
      end
      else if (dn_step & ~up_step)
      begin
         o_count <= o_count - 32'h1;
         o_direction <= 1'b0;
      end
   end

   // ==================================================
   // Period timebase and averaging window
   reg [31:0] gap_q;
   reg [31:0] samples_q [0:127];
   reg [6:0] wr_ptr_q;
   reg [7:0] fill_q;
   reg [38:0] sum_q;
   reg seen_q;
   wire [7:0] depth;
   wire [6:0] old_idx;
   wire [31:0] old_sample;
   wire [38:0] sum_next;
   // Depth clamped to 1..128 so the divider never sees zero
   assign depth = (i_avg_depth == 8'h0) ? 8'h1 :
      (i_avg_depth > `AVG_MAX) ? `AVG_MAX : i_avg_depth;
   assign old_idx = wr_ptr_q - depth[6:0];
   assign old_sample = (fill_q >= depth) ? samples_q[old_idx] : 32'h0;
   assign sum_next = sum_q + {7'h0, gap_q} - {7'h0, old_sample};
   // Gap counter measures clock cycles between qualifying edges
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         gap_q <= 32'h0;
         wr_ptr_q <= 7'h0;
         fill_q <= 8'h0;
         sum_q <= 39'h0;
         seen_q <= 1'b0;
      end
      else if (i_clear)
      begin
         gap_q <= 32'h0;
         fill_q <= 8'h0;
         sum_q <= 39'h0;
         seen_q <= 1'b0;
      end
      else if (any_step)
      begin
         gap_q <= 32'h1;
         seen_q <= 1'b1;
         if (seen_q)
         begin
            wr_ptr_q <= wr_ptr_q + 7'h1;
            sum_q <= sum_next; // Running sum over the window
            if (fill_q < depth)
               fill_q <= fill_q + 8'h1;
         end
      end
      else if (gap_q != 32'hffffffff)
         gap_q <= gap_q + 32'h1; // Saturates rather than wrap
   end
   // Sample memory has no reset; unwritten entries are masked by fill_q
   always @(posedge i_clock)
   begin
      if (any_step & seen_q & ~i_clear)
         samples_q[wr_ptr_q] <= gap_q;
   end
   // Divide in a clocked step; a depth change restarts nothing, and the running sum keeps the old window's samples
   wire [7:0] n_used;
   assign n_used = (fill_q < depth) ? ((fill_q == 8'h0) ? 8'h1 : fill_q) : depth;
   // Quotient keeps the sum's width; a mean of 32-bit gaps always fits the low word
   wire [38:0] mean_full;
   assign mean_full = sum_q / {31'h0, n_used};
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
         o_period <= 32'h0;
      else
         o_period <= mean_full[31:0]; // Mean in clock cycles
   end

   // ==================================================
   // Stall detection
   reg [31:0] stall_q;
   always @(posedge i_clock or posedge i_reset)
   begin
      if (i_reset)
      begin
         stall_q <= 32'h0;
         o_stopped <= 1'b0;
      end
      else if (any_step | i_clear)
      begin
         stall_q <= 32'h0; // Restart on every pulse that moves the count, and on clear
         o_stopped <= 1'b0;
      end
      else if (stall_q >= i_stall_timeout)
         o_stopped <= 1'b1;
      else
         stall_q <= stall_q + 32'h1;
   end
endmodule // pulse_channel
`default_nettype wire

// [bench/pulse_counter_period_timer_checker.sv]
// Register port assertions for the pulse counter bank
`timescale 1ns/100ps
`default_nettype none
module pulse_counter_period_timer_checker (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [7:0] i_address,
   input wire logic [31:0] i_write_data,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [31:0] o_read_data,
   input wire logic [3:0] o_read_select,
   input wire logic o_read_error,
   input wire logic o_interrupt
);
   // ==========================================
   // Shadow copies of selector and mask
   logic [3:0] sel_q;
   logic [1:0] mask_q;
   wire logic chan_reg = i_address >= 8'h04 && i_address <= 8'h18 && i_address[1:0] == 2'h0;
   // Tracked from writes so that refusals can be predicted
   always_ff @(posedge i_clock or negedge i_resetn)
      if (!i_resetn)
      begin
         sel_q <= 4'h8;
         mask_q <= 2'h0;
      end
      else if (i_write && i_address == 8'h00)
         sel_q <= (i_write_data > 32'h7) ? 4'h8 : i_write_data[3:0];
      else if (i_write && i_address == 8'h20)
         mask_q <= i_write_data[1:0];
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   sequence s_bad_read;
      i_read && sel_q[3] && chan_reg;
   endsequence
   sequence s_good_read;
      i_read && !sel_q[3];
   endsequence
   a_refused_read: assert property (s_bad_read |=> o_read_error && o_read_data == 32'h4)
      else $error("refused read not flagged");
   a_error_cause: assert property (o_read_error |-> $past(i_read) && o_read_select == 4'h8)
      else $error("error without refused read");
   a_good_select: assert property (s_good_read |=> !o_read_error && o_read_select == {1'b0, sel_q[2:0]})
      else $error("wrong index returned");
   a_idle_outputs: assert property (!i_read |=> o_read_data == 32'h0 && o_read_select == 4'h8 && !o_read_error)
      else $error("read outputs not idle");
   a_select_range: assert property (o_read_select <= 4'h8)
      else $error("index out of range");
   a_sel_readback: assert property (i_read && i_address == 8'h00 |=> o_read_data == {28'h0, sel_q})
      else $error("selector readback wrong");
   a_error_irq: assert property (o_read_error && mask_q[0] |-> o_interrupt)
      else $error("error interrupt missing");
   a_mask_off: assert property (mask_q == 2'h0 |-> !o_interrupt)
      else $error("masked interrupt seen");
endmodule // pulse_counter_period_timer_checker
bind pulse_counter_period_timer pulse_counter_period_timer_checker chk (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_address(i_address), .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
   .o_read_data(o_read_data), .o_read_select(o_read_select), .o_read_error(o_read_error), .o_interrupt(o_interrupt));
`default_nettype wire

// [bench/pulse_sensor.sv]
// Behavioural pulse sensor driving the up and down pins
`timescale 1ns/100ps
`default_nettype none
module pulse_sensor (
   input wire logic i_clock,
   output logic [7:0] o_up_pins,
   output logic [7:0] o_down_pins
);
   // ==========================================
   // Pins idle low between pulses
   initial
   begin
      o_up_pins = 8'h00;
      o_down_pins = 8'h00;
   end
   // Set one pin of the chosen counter and hold it
   task automatic drive(input int ch, input bit dn, input bit lvl, input int hold);
      @(posedge i_clock);
      if (dn)
         o_down_pins[ch] <= lvl;
      else
         o_up_pins[ch] <= lvl;
      repeat (hold - 1) @(posedge i_clock);
   endtask
endmodule // pulse_sensor
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the pulse counter bank
`timescale 1ns/100ps
`default_nettype none
`include "pulse_counter_consts.vh"
module testbench;
   localparam int STALL = 200;
   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic [31:0] i_write_data = 32'h0;
   logic i_write = 1'b0;
   logic i_read = 1'b0;
   wire logic [7:0] up_pins;
   wire logic [7:0] down_pins;
   wire logic [31:0] read_data;
   wire logic [3:0] read_select;
   wire logic read_error;
   wire logic irq;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int m_sel = 8;
   int unsigned m_cnt [8] = '{default: 0};
   int m_ctrl [8] = '{default: 0};
   int unsigned samples [$];
   int depths [3] = '{1, 3, 128};
   always #5 i_clock = ~i_clock;
   pulse_counter_period_timer #(.NUM_CHANNELS(8), .STALL_DEFAULT(STALL)) dut (.i_clock(i_clock),
      .i_resetn(i_resetn), .i_up_pins(up_pins), .i_down_pins(down_pins), .i_address(i_address),
      .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read), .o_read_data(read_data),
      .o_read_select(read_select), .o_read_error(read_error), .o_interrupt(irq));
   pulse_sensor sensor (.i_clock(i_clock), .o_up_pins(up_pins), .o_down_pins(down_pins));
   // ==========================================
   // Verdict and watchdog
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Generous ceiling: the run needs about a thousand cycles
   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   // ==========================================
   // Compare tasks
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: data %h, model %h", $time, got, exp);
      end
   endtask
   task automatic chk_sel(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: index %h, model %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: flag %b, model %b", $time, got, exp);
      end
   endtask
   // ==========================================
   // Bus cycles with the reference model kept beside them
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_address <= a;
      i_write_data <= d;
      i_write <= 1'b1;
      @(posedge i_clock);
      i_write <= 1'b0;
      #1;
      if (a == `ADDR_SELECT)
         m_sel = d > 7 ? 8 : int'(d);
      if (a == `ADDR_CTRL && m_sel < 8)
      begin
         m_ctrl[m_sel] = d;
         if (d[3])
         begin
            m_cnt[m_sel] = 0;
            samples.delete();
         end
      end
   endtask
   // Refused accesses answer with the error word whatever the model holds
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bit bad;
      bad = m_sel == 8 && a >= `ADDR_CTRL && a <= `ADDR_STATUS;
      @(posedge i_clock);
      i_address <= a;
      i_read <= 1'b1;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1;
      chk_word(read_data, bad ? 32'h4 : exp);
      chk_sel(read_select, bad ? 4'h8 : 4'(m_sel));
      chk_flag(read_error, bad);
   endtask
   // One pulse, next rising edge gap cycles later
   task automatic step(input int ch, input bit dn, input int gap);
      sensor.drive(ch, dn, 1'b1, 4);
      sensor.drive(ch, dn, 1'b0, gap - 4);
      if (m_ctrl[ch][0] && (!dn || m_ctrl[ch][2]))
         m_cnt[ch] += dn ? 32'hffffffff : 32'h1;
   endtask
   task automatic burst(input int ch, input int n);
      int g;
      for (int i = 0; i < n; i++)
      begin
         g = 8 + $urandom % 32;
         step(ch, 1'b0, g);
         if (i < n - 1)
            samples.push_back(g);
      end
   endtask
   function automatic int unsigned mean(input int d);
      int unsigned s = 0;
      int n;
      n = samples.size() < d ? samples.size() : d;
      for (int i = samples.size() - n; i < samples.size(); i++)
         s += samples[i];
      return s / n;
   endfunction
   // ==========================================
   // Main sequence
   initial
   begin
      int unsigned seed;
      seed = $urandom(93504);
      repeat (6) @(posedge i_clock);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clock);
      rd(`ADDR_SELECT, 32'h8);
      wr(`ADDR_IRQ_MASK, 32'h1);
      rd(`ADDR_COUNT, 32'h0);
      chk_flag(irq, 1'b1);
      wr(`ADDR_IRQ_STAT, 32'h1);
      chk_flag(irq, 1'b0);
      wr(`ADDR_IRQ_MASK, 32'h0);
      wr(`ADDR_SELECT, 32'h9);
      rd(`ADDR_SELECT, 32'h8);
      for (int ch = 0; ch < 8; ch++)
      begin
         wr(`ADDR_SELECT, ch);
         rd(`ADDR_TIMEOUT, STALL);
         rd(`ADDR_AVG, 32'h1);
      end
      wr(`ADDR_SELECT, 32'h2);
      wr(`ADDR_AVG, 32'h0);
      rd(`ADDR_AVG, 32'h1);
      wr(`ADDR_AVG, 32'hc8);
      rd(`ADDR_AVG, 32'h80);
      wr(`ADDR_CTRL, 32'h1);
      foreach (depths[i])
      begin
         wr(`ADDR_AVG, depths[i]);
         burst(2, 6);
         rd(`ADDR_PERIOD, mean(depths[i]));
         rd(`ADDR_COUNT, m_cnt[2]);
         rd(`ADDR_STATUS, 32'h1);
         wr(`ADDR_CTRL, 32'h9);
         rd(`ADDR_COUNT, 32'h0);
      end
      // Short programmed timeout, stop event unmasked
      wr(`ADDR_TIMEOUT, 32'h64);
      wr(`ADDR_IRQ_STAT, 32'h3);
      wr(`ADDR_IRQ_MASK, 32'h2);
      step(2, 1'b0, 8);
      repeat (60) @(posedge i_clock);
      rd(`ADDR_STATUS, 32'h1);
      repeat (60) @(posedge i_clock);
      rd(`ADDR_STATUS, 32'h3);
      chk_flag(irq, 1'b1);
      wr(`ADDR_IRQ_STAT, 32'h2);
      chk_flag(irq, 1'b0);
      step(2, 1'b0, 8);
      rd(`ADDR_STATUS, 32'h1);
      // Down source across zero, then halted counting
      wr(`ADDR_SELECT, 32'h5);
      wr(`ADDR_CTRL, 32'h5);
      step(5, 1'b1, 8);
      rd(`ADDR_COUNT, m_cnt[5]);
      rd(`ADDR_STATUS, 32'h0);
      step(5, 1'b0, 8);
      rd(`ADDR_COUNT, m_cnt[5]);
      rd(`ADDR_STATUS, 32'h1);
      // Nonzero count before the stop, so a stop that cleared would show
      step(5, 1'b0, 8);
      wr(`ADDR_CTRL, 32'h4);
      step(5, 1'b0, 8);
      rd(`ADDR_COUNT, m_cnt[5]);
      // Falling edges only; down source disabled
      wr(`ADDR_SELECT, 32'h3);
      wr(`ADDR_CTRL, 32'h3);
      sensor.drive(3, 1'b0, 1'b1, 10);
      rd(`ADDR_COUNT, 32'h0);
      sensor.drive(3, 1'b0, 1'b0, 10);
      m_cnt[3] = 1;
      rd(`ADDR_COUNT, m_cnt[3]);
      step(3, 1'b1, 8);
      rd(`ADDR_COUNT, m_cnt[3]);
      rd(8'h40, 32'h0);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
